// ### tb/cie_irq_entry_asserts.sv
module cie_irq_entry_asserts #(
    parameter int NSRC = 8,
    parameter int PCW = 13,
    parameter int SPW = 11
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic asleep,
    input wire cie_pkg::cie_ctl_t ctl,
    input wire cie_pkg::cie_alu_flags_t alu_flags,
    input wire logic [SPW-1:0] sp_in,
    input wire logic [7:0] cpu_flag_register,
    input wire logic take_irq,
    input wire logic push_pc,
    input wire logic pop_pc,
    input wire logic vector_go,
    input wire logic [SPW-1:0] sp_out,
    input wire logic sp_load
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Stack steps of entry and return, both two bytes
    sequence push_s; push_pc && sp_load && sp_out == sp_in - SPW'(2); endsequence
    sequence pop_s; pop_pc && sp_load && sp_out == sp_in + SPW'(2); endsequence
    entry_push_a: assert property (take_irq && !asleep |=> push_s)
        else $error("entry push missing or wrong stack step");
    wake_push_a: assert property (take_irq && asleep |-> ##5 push_s)
        else $error("push after wake not five cycles after take");
    entry_clears_i_a: assert property (take_irq |-> !cpu_flag_register[7])
        else $error("global enable still set on entry");
    entry_time_a: assert property (take_irq && !asleep |-> ##4 vector_go)
        else $error("vector fetch not four cycles after take");
    wake_time_a: assert property (take_irq && asleep |-> ##8 vector_go)
        else $error("vector fetch not eight cycles after take from sleep");
    return_pop_a: assert property (pop_pc |-> pop_s ##3 cpu_flag_register[7])
        else $error("return pop or enable restore wrong");
    no_take_off_a: assert property (!cpu_flag_register[7] |=> !take_irq)
        else $error("interrupt taken with global enable off");
    cli_blocks_a: assert property (ctl.clear_irq_enable_op |=> !take_irq)
        else $error("interrupt taken in clear-enable cycle");
    sign_bit_a: assert property (cpu_flag_register[4] ==
        (cpu_flag_register[2] ^ cpu_flag_register[3]))
        else $error("sign bit differs from n xor v");
    alu_update_a: assert property (ctl.alu_upd |=>
        {cpu_flag_register[5], cpu_flag_register[3:0]} == $past(alu_flags))
        else $error("alu flags not loaded");
endmodule : cie_irq_entry_asserts

// ### tb/cie_irq_entry_bench.sv
module cie_irq_entry_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst = 1, vts = 0, fuse = 0, lock_a = 0, asleep = 0;
    logic [7:0] ev = 0, lvl = 0, is_lvl = 0, en = 0, clr = 0, fwd = 0, flags, pend;
    logic take_irq, push_pc, pop_pc, vector_go, sp_load;
    logic [12:0] vpc, rpc;
    logic [10:0] sp_in, sp_out;
    cie_pkg::cie_ctl_t ctl = '0;
    cie_pkg::cie_alu_flags_t alu = '0;
    int mismatches = 0, total_checks = 0;
    always #5 clock = ~clock;
    cie_stack_model cie_stack_model_i (.clock(clock), .rst(rst), .sp_load(sp_load),
        .sp_out(sp_out), .sp_in(sp_in));
    cie_irq_entry cie_irq_entry_i (.clock(clock), .rst(rst), .flag_event(ev), .level_req(lvl),
        .src_is_level(is_lvl), .src_enable(en), .flag_clear_wr(clr), .vector_table_select(vts),
        .reset_vector_fuse(fuse), .app_section_lock_bit(lock_a), .boot_section_lock_bit(1'b0),
        .asleep(asleep), .ctl(ctl), .alu_flags(alu), .flag_wr_data(fwd), .cur_pc(13'h0000),
        .ret_pc(13'h0010), .sp_in(sp_in), .cpu_flag_register(flags), .flag_pending(pend),
        .take_irq(take_irq), .seq_busy(), .push_pc(push_pc), .pop_pc(pop_pc),
        .vector_pc(vpc), .vector_go(vector_go), .sp_out(sp_out), .sp_load(sp_load),
        .reset_pc(rpc));
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    // Bounded wait for the vector fetch pulse
    task automatic wait_go;
        int i;
        for (i = 0; i < 40 && vector_go !== 1'b1; i++) tick(1);
        if (vector_go !== 1'b1) begin
            mismatches++;
            end_sim();
        end
    endtask : wait_go
    task automatic set_flags(input logic [7:0] v);
        ctl.flag_wr = 1;
        fwd = v;
        tick(1);
        ctl.flag_wr = 0;
    endtask : set_flags
    task automatic pulse(input logic [7:0] m);
        ev = m;
        tick(1);
        ev = 0;
    endtask : pulse
    initial begin
        ctl.boundary = 1;
        tick(4);
        rst = 0;
        tick(1);
        chk(flags, 8'h00);
        chk(rpc, 13'h0000);
        en = 8'hff;
        pulse(8'h0a);
        tick(3);
        chk(pend, 8'h0a);
        set_flags(8'h80);
        wait_go();
        chk(vpc, 13'h0004);
        chk(pend, 8'h08);
        chk(flags[7], 1'b0);
        chk(sp_in, 11'h0fe);
        ctl.return_from_irq_op = 1;
        tick(1);
        ctl.return_from_irq_op = 0;
        wait_go();
        chk(vpc, 13'h0008);
        chk(pend, 8'h00);
        en = 8'h00;
        set_flags(8'h80);
        pulse(8'h03);
        tick(3);
        chk(flags[7], 1'b1);
        clr = 8'h02;
        tick(1);
        clr = 8'h00;
        chk(pend, 8'h01);
        // Level source that leaves before it is enabled
        is_lvl = 8'h04;
        lvl = 8'h04;
        tick(2);
        lvl = 0;
        en = 8'h04;
        tick(6);
        chk(flags[7], 1'b1);
        lvl = 8'h04;
        wait_go();
        lvl = 0;
        chk(vpc, 13'h0006);
        is_lvl = 0;
        // Locked vectors in boot block a take until the lock drops
        vts = 1;
        lock_a = 1;
        en = 8'h01;
        set_flags(8'h80);
        tick(6);
        chk(flags[7], 1'b1);
        lock_a = 0;
        wait_go();
        chk(vpc, 13'h1c02);
        // Flag latched while disabled, then enable and clear-enable meet a request
        pulse(8'h01);
        ctl.flag_wr = 1;
        fwd = 8'h80;
        tick(1);
        ctl.flag_wr = 0;
        ctl.clear_irq_enable_op = 1;
        tick(1);
        ctl.clear_irq_enable_op = 0;
        tick(2);
        chk(pend, 8'h01);
        chk(flags[7], 1'b0);
        ctl.store_bit_to_copy_op = 1;
        ctl.bst_val = 1;
        tick(1);
        ctl.store_bit_to_copy_op = 0;
        chk(flags[6], 1'b1);
        alu = 5'h1b;
        ctl.alu_upd = 1;
        tick(1);
        ctl.alu_upd = 0;
        chk(flags, 8'h7b);
        asleep = 1;
        set_flags(8'h80);
        wait_go();
        asleep = 0;
        chk(vpc, 13'h1c02);
        fuse = 1;
        rst = 1;
        tick(2);
        rst = 0;
        tick(2);
        chk(rpc, 13'h1c00);
        end_sim();
    end
endmodule : cie_irq_entry_bench
bind cie_irq_entry cie_irq_entry_asserts #(.NSRC(NSRC), .PCW(PCW), .SPW(SPW))
    cie_irq_entry_asserts_i (.clock(clock), .rst(rst), .asleep(asleep), .ctl(ctl),
    .alu_flags(alu_flags), .sp_in(sp_in), .cpu_flag_register(cpu_flag_register),
    .take_irq(take_irq), .push_pc(push_pc), .pop_pc(pop_pc), .vector_go(vector_go),
    .sp_out(sp_out), .sp_load(sp_load));

// ### tb/cie_stack_model.sv
// Core stack pointer as the sequencer keeps it; it only follows loads
module cie_stack_model #(
    parameter int SPW = 11,
    parameter logic [SPW-1:0] SP_INIT = 11'h100
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sp_load,
    input wire logic [SPW-1:0] sp_out,
    output logic [SPW-1:0] sp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // only the return address is stacked, never the flags
    always_ff @(posedge clock or posedge rst) begin
        if (rst) sp_in <= SP_INIT;
        else if (sp_load) sp_in <= sp_out;
    end
endmodule : cie_stack_model

// ### verilog/cie_cfg.svh
`ifndef CIE_CFG_SVH
`define CIE_CFG_SVH
// Status flag bit positions
`define CIE_BIT_I 7
`define CIE_BIT_T 6
`define CIE_BIT_H 5
`define CIE_BIT_S 4
`define CIE_BIT_V 3
`define CIE_BIT_N 2
`define CIE_BIT_Z 1
`define CIE_BIT_C 0
// Reset value of the flag register
`define CIE_FLAGS_RST 8'h00
// Cycle counts for entry, sleep extra and return
`define CIE_ENTRY_CYC 4
`define CIE_WAKE_CYC 4
`define CIE_RET_CYC 4
// Stack pointer change per return address
`define CIE_SP_STEP 2
`endif

// ### verilog/cie_irq_entry.sv
`include "cie_cfg.svh"
// How it works
// - Serve only when local and global enable
// - Boot lock bits may block by PC
// - Lower vector index wins, reset first
// - Vector select moves table to boot start
// - Entry clears global enable, return sets
// - Hardware clears served flag on vectoring
// - Writing one clears a flag
// - Disabled events stay latched until served
// - Level sources request only while present
// - One main instruction after return
// - Clear-enable blocks even same-cycle requests
// - Instruction after set-enable runs first
// - Entry takes four cycles pushing PC
// - Wait for multi-cycle instruction end
// - Wake from sleep adds four cycles
// - Return four cycles, pop PC, SP+2
// - ALU operations update status flags
// - Bit 7 is global enable
// - Bit 6 is bit copy store
// - Sign bit equals N xor V
// - H5 V3 N2 Z1 C0 flag layout
// - Entry push lowers SP by two
module cie_irq_entry #(
    parameter int NSRC = 8,
    parameter int PCW = 13,
    parameter int SPW = 11,
    parameter logic [PCW-1:0] BOOT_START = 13'h1c00,
    parameter logic [PCW-1:0] VEC_STEP = 13'h0002
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [NSRC-1:0] flag_event,
    input wire logic [NSRC-1:0] level_req,
    input wire logic [NSRC-1:0] src_is_level,
    input wire logic [NSRC-1:0] src_enable,
    input wire logic [NSRC-1:0] flag_clear_wr,
    input wire logic vector_table_select,
    input wire logic reset_vector_fuse,
    input wire logic app_section_lock_bit,
    input wire logic boot_section_lock_bit,
    input wire logic asleep,
    input wire cie_pkg::cie_ctl_t ctl,
    input wire cie_pkg::cie_alu_flags_t alu_flags,
    input wire logic [7:0] flag_wr_data,
    input wire logic [PCW-1:0] cur_pc,
    input wire logic [PCW-1:0] ret_pc,
    input wire logic [SPW-1:0] sp_in,
    output logic [7:0] cpu_flag_register,
    output logic [NSRC-1:0] flag_pending,
    output logic take_irq,
    output logic seq_busy,
    output logic push_pc,
    output logic pop_pc,
    output logic [PCW-1:0] vector_pc,
    output logic vector_go,
    output logic [SPW-1:0] sp_out,
    output logic sp_load,
    output logic [PCW-1:0] reset_pc
);
    cie_pkg::cie_state_t state_q, state_d;
    logic [7:0] flags_q, flags_d;
    logic [NSRC-1:0] pend_q, pend_d;
    logic [2:0] cnt_q, cnt_d;
    logic hold_q, hold_d;
    logic [$clog2(NSRC+1)-1:0] win_q, win_d;
    logic [PCW-1:0] vec_q;
    logic vgo_q, push_q, pop_q, spl_q, take_q;
    logic [SPW-1:0] sp_q;
    logic [PCW-1:0] rpc_q;
    logic busy_q;

    // Requests: latched flags or live levels, each gated by its own enable
    wire [NSRC-1:0] raw_req;
    wire [NSRC-1:0] en_req;
    // Per-source request terms; each slice is independent, so the loop keeps
    // one source's selection and gating together
    for (genvar g = 0; g < NSRC; g++) begin : g_src
        // Level sources live
        // A level source never latches, so a vanished condition leaves no trace
        assign raw_req[g] = src_is_level[g] ? level_req[g] : pend_q[g];
        assign en_req[g] = raw_req[g] & src_enable[g];
    end

    // Boot protection: suppress while PC sits in the locked section
    // The lock only looks at where the code runs and where the table lives;
    // pending flags stay latched while blocked, so nothing is lost
    wire in_boot;
    wire lock_block;
    assign in_boot = cur_pc >= BOOT_START;
    assign lock_block = (app_section_lock_bit & ~in_boot & vector_table_select)
        | (boot_section_lock_bit & in_boot & ~vector_table_select);

    // Fixed priority search, lowest index found last wins
    // Walking down from the top keeps the loop free of early exits, which
    // gives a plain priority chain rather than a break-driven one
    logic [$clog2(NSRC+1)-1:0] sel;
    logic any_req;
    always_comb begin
        sel = '0;
        any_req = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (en_req[i]) begin
                sel = ($clog2(NSRC+1))'(i);
                any_req = 1'b1;
            end
        end
    end

    // Take decision: clear-enable wins over a request in the same cycle
    // The live clear strobe is looked at, not only the stored enable bit,
    // because the stored bit would still read one during that cycle
    wire can_take;
    assign can_take = (state_q == cie_pkg::CIE_RUN) & any_req & ~lock_block
        & flags_q[`CIE_BIT_I] & ~ctl.clear_irq_enable_op & ~hold_q & ctl.boundary;

    // Vector address, index 0 is reset so sources start at one
    // The address is rebuilt every cycle from the held winner, so a change
    // of the table select during entry moves the fetch as well
    wire [PCW-1:0] vec_base;
    wire [PCW-1:0] vec_addr;
    assign vec_base = vector_table_select ? BOOT_START : '0;
    assign vec_addr = vec_base + PCW'(({1'b0, win_q} + 1) * VEC_STEP);

    // Sequencer next state
    // Run waits for a take or a return; sleep adds its own count before the
    // entry count; the hold bit makes the first boundary after a return or
    // a set-enable pass without a take, so one main instruction runs
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        win_d = win_q;
        hold_d = hold_q;
        if (ctl.boundary && state_q == cie_pkg::CIE_RUN) begin
            hold_d = 1'b0;
        end
        case (state_q)
            cie_pkg::CIE_RUN: begin
                if (can_take) begin
                    win_d = sel;
                    state_d = asleep ? cie_pkg::CIE_WAKE : cie_pkg::CIE_ENTRY;
                    cnt_d = asleep ? 3'(`CIE_WAKE_CYC - 1) : 3'(`CIE_ENTRY_CYC - 1);
                end else if (ctl.return_from_irq_op && ctl.boundary) begin
                    state_d = cie_pkg::CIE_RET;
                    cnt_d = 3'(`CIE_RET_CYC - 1);
                end
                if (ctl.sei && ctl.boundary) begin
                    hold_d = 1'b1;
                end
            end
            cie_pkg::CIE_WAKE: begin
                cnt_d = cnt_q - 3'h1;
                if (cnt_q == 3'h0) begin
                    state_d = cie_pkg::CIE_ENTRY;
                    cnt_d = 3'(`CIE_ENTRY_CYC - 1);
                end
            end
            cie_pkg::CIE_ENTRY: begin
                cnt_d = cnt_q - 3'h1;
                if (cnt_q == 3'h0) begin
                    state_d = cie_pkg::CIE_RUN;
                end
            end
            cie_pkg::CIE_RET: begin
                cnt_d = cnt_q - 3'h1;
                if (cnt_q == 3'h0) begin
                    state_d = cie_pkg::CIE_RUN;
                    hold_d = 1'b1;
                end
            end
            default: begin
                state_d = cie_pkg::CIE_RUN;
            end
        endcase
    end

    // Pending flags: a new event beats both software and hardware clears
    wire [NSRC-1:0] served_clr;
    assign served_clr = can_take ? (NSRC'(1) << sel) & ~src_is_level : '0;
    assign pend_d = (pend_q & ~flag_clear_wr & ~served_clr) | flag_event;

    // Status register; handlers save it themselves, nothing is stacked
    // Later writes in this process override earlier ones: hardware entry and
    // return win over a software write of the enable bit in the same cycle
    wire entry_end;
    wire ret_end;
    assign entry_end = state_q == cie_pkg::CIE_ENTRY && cnt_q == 3'h0;
    assign ret_end = state_q == cie_pkg::CIE_RET && cnt_q == 3'h0;
    always_comb begin
        flags_d = flags_q;
        if (ctl.flag_wr) begin
            flags_d = flag_wr_data;
        end
        if (ctl.alu_upd) begin
            flags_d[`CIE_BIT_H] = alu_flags.h;
            flags_d[`CIE_BIT_V] = alu_flags.v;
            flags_d[`CIE_BIT_N] = alu_flags.n;
            flags_d[`CIE_BIT_Z] = alu_flags.z;
            flags_d[`CIE_BIT_C] = alu_flags.c;
        end
        if (ctl.store_bit_to_copy_op) begin
            flags_d[`CIE_BIT_T] = ctl.bst_val;
        end
        if (ctl.sei) begin
            flags_d[`CIE_BIT_I] = 1'b1;
        end
        if (ctl.clear_irq_enable_op) begin
            flags_d[`CIE_BIT_I] = 1'b0;
        end
        if (can_take) begin
            flags_d[`CIE_BIT_I] = 1'b0;
        end
        if (ret_end) begin
            flags_d[`CIE_BIT_I] = 1'b1;
        end
        flags_d[`CIE_BIT_S] = flags_d[`CIE_BIT_N] ^ flags_d[`CIE_BIT_V];
    end

    // State and flag registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= cie_pkg::CIE_RUN;
            cnt_q <= 3'h0;
            win_q <= '0;
            hold_q <= 1'b0;
            pend_q <= '0;
            flags_q <= `CIE_FLAGS_RST;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            win_q <= win_d;
            hold_q <= hold_d;
            pend_q <= pend_d;
            flags_q <= flags_d;
        end
    end

    // Stack pointer: entry lowers by two, return raises by two
    wire first_entry;
    wire [SPW-1:0] sp_next;
    wire [SPW-1:0] sp_pushed;
    wire [SPW-1:0] sp_popped;
    // The core only loads sp_out with sp_load, so the pointer need not be
    // kept here; computing both steps each cycle keeps the register short
    assign first_entry = state_q == cie_pkg::CIE_ENTRY && cnt_q == 3'(`CIE_ENTRY_CYC - 1);
    assign sp_pushed = sp_in - SPW'(`CIE_SP_STEP);
    assign sp_popped = sp_in + SPW'(`CIE_SP_STEP);
    assign sp_next = first_entry ? sp_pushed : sp_popped;

    // Registered outputs toward the core sequencer
    // Every pulse leaves one cycle after the state that causes it, so the
    // core sees clean flop outputs and no decode glitches
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            take_q <= 1'b0;
            push_q <= 1'b0;
            pop_q <= 1'b0;
            spl_q <= 1'b0;
            sp_q <= '0;
            vgo_q <= 1'b0;
            vec_q <= '0;
            rpc_q <= '0;
        end else begin
            busy_q <= state_d != cie_pkg::CIE_RUN;
            take_q <= can_take;
            push_q <= first_entry;
            pop_q <= state_q == cie_pkg::CIE_RET && cnt_q == 3'(`CIE_RET_CYC - 1);
            spl_q <= first_entry | (state_q == cie_pkg::CIE_RET && cnt_q == 3'(`CIE_RET_CYC - 1));
            sp_q <= sp_next;
            vgo_q <= entry_end;
            vec_q <= vec_addr;
            rpc_q <= reset_vector_fuse ? BOOT_START : '0;
        end
    end

    // Ret_pc is captured by the core on pop; kept visible for the sequencer
    wire unused_ok;
    assign unused_ok = ^ret_pc;

    assign cpu_flag_register = flags_q;
    assign flag_pending = pend_q;
    assign take_irq = take_q;
    // Busy mirrors the state register, held in its own flop
    assign seq_busy = busy_q;
    assign push_pc = push_q;
    assign pop_pc = pop_q;
    assign vector_pc = vec_q;
    assign vector_go = vgo_q;
    assign sp_out = sp_q;
    assign sp_load = spl_q;
    assign reset_pc = rpc_q;
endmodule : cie_irq_entry

// ### verilog/cie_pkg.sv
package cie_pkg;
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        CIE_RUN = 4'h1,
        CIE_WAKE = 4'h2,
        CIE_ENTRY = 4'h4,
        CIE_RET = 4'h8
    } cie_state_t;

    // ALU flag result handed in by the execute stage
    typedef struct packed {
        logic h;
        logic v;
        logic n;
        logic z;
        logic c;
    } cie_alu_flags_t;

    // Instruction stream controls seen by this block
    typedef struct packed {
        logic boundary;
        logic sei;
        logic clear_irq_enable_op;
        logic return_from_irq_op;
        logic store_bit_to_copy_op;
        logic bst_val;
        logic alu_upd;
        logic flag_wr;
    } cie_ctl_t;
endpackage : cie_pkg
